// *** rtl/uplink_decoder_regs.vh ***
// constants for the uplink interrogation field decoder
`ifndef UPLINK_DECODER_REGS_VH
`define UPLINK_DECODER_REGS_VH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_FMT 8'h08
`define REG_SURV 8'h0c
`define REG_MSG_LO 8'h10
`define REG_MSG_MID 8'h14
`define REG_MSG_HI 8'h18
`define REG_ADDR 8'h1c
// control fields
`define CTRL_ENABLE 0
`define CTRL_LOCK_CLR 1
`define CTRL_RESET_VAL 32'h0000_0001
// uplink formats
`define UF_SHORT_AIR 5'h00
`define UF_SURV_ALT 5'h04
`define UF_SURV_ID 5'h05
`define UF_ALL_CALL 5'h0b
`define UF_LONG_AIR 5'h10
`define UF_COMMA_ALT 5'h14
`define UF_COMMA_ID 5'h15
`define UF_ELM 5'h18
// message lengths in bits
`define LEN_SHORT 7'h38
`define LEN_LONG 7'h70
`define AP_BITS 24
`endif

// *** rtl/uplink_field_decoder.v ***
// uplink interrogation field decoder with wishbone register access
//
// The address map and the Wishbone interface to the registers were decided locally.
`default_nettype none
`include "uplink_decoder_regs.vh"
// Overview of operation
// - last 24 bits are address parity
// - copy AQ into format 0/16 reply
// - BDS selects ground-initiated Comm B register
// - decode DI designator codes
// - extract II from all call
// - capture 56-bit Comm A message
// - capture 80-bit ELM segment in format 24
// - capture MU air-to-air, not Comm A
// - NC gives ELM segment number
// - act on PC protocol commands
// - decode PR reply probability codes
// - random reply decision for PR 1-4 and 9-12
// - disregard-lockout PR overrides lockout
// - decode RC segment kind, final requests Comm D
// - RL selects reply format 0 or 16
// - map RR to short or long reply
// - RR msb set gives reply source number
// - SD interpreted per DI
// - IIS from SD when DI 0,1,7
// - first field is uplink format
// - lockout suppresses all call replies only
module uplink_field_decoder (
   input wire clk,
   input wire rstn,
   input wire bit_in,
   input wire bit_valid,
   input wire frame_end,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire wb_stb_i,
   input wire wb_cyc_i,
   output reg wb_ack_o,
   output reg fields_valid,
   output reg [4:0] uf,
   output reg aq_copy,
   output reg [7:0] bds,
   output reg [2:0] di,
   output reg [3:0] ii,
   output reg [3:0] iis,
   output reg [15:0] sd,
   output reg [79:0] message,
   output reg msg_is_comm_a,
   output reg msg_is_air_air,
   output reg msg_is_elm,
   output reg [3:0] nc,
   output reg [1:0] rc,
   output reg comm_d_request,
   output reg [2:0] pc,
   output reg lockout_cmd,
   output reg [2:0] closeout,
   output reg [3:0] pr,
   output reg [4:0] rr,
   output reg long_reply,
   output reg [3:0] reply_source,
   output reg reply_df16,
   output reg reply_enable,
   output reg [23:0] ap,
   output reg [2:0] sd_kind,
   output reg lockout
);
   reg [111:0] shreg;
   reg [6:0] count;
   reg [31:0] ctrl;
   reg [15:0] lfsr;
   reg [31:0] frame_count;
   wire [111:0] m;
   wire [4:0] f;
   wire elm_format;
   wire short_len;
   wire long_len;
   wire frame_ok;
   wire take_bit;
   wire ctrl_enable;
   wire [6:0] next_count;
   wire [15:0] next_lfsr;
   wire rl_field;
   wire aq_field;
   wire [7:0] bds_field;
   wire [2:0] pc_field;
   wire [4:0] rr_field;
   wire [2:0] di_field;
   wire [15:0] sd_field;
   wire [3:0] iis_field;
   wire [3:0] pr_field;
   wire [3:0] ii_field;
   wire [55:0] ma_field;
   wire [55:0] mu_field;
   wire [1:0] rc_field;
   wire [3:0] nc_field;
   wire [79:0] mc_field;
   wire [23:0] ap_field;
   wire [4:0] next_uf;
   wire [3:0] next_reply_source;
   wire comm_d_field;
   wire iis_present;
   wire pr_no_reply;
   wire pr_override;
   wire is_surv;
   wire is_comm_a;
   reg pr_reply;
   reg [3:0] pr_mask;
   reg [2:0] next_sd_kind;
   reg [2:0] next_closeout;
   reg [31:0] next_rdata;
   wire [31:0] status_word;
   wire bus_req;
   wire bus_done;
   wire ctrl_write;
   wire lock_clear;
   wire lock_set;

   // frame length and bit acceptance
   assign ctrl_enable = ctrl[`CTRL_ENABLE];
   assign short_len = (count == `LEN_SHORT);
   assign long_len = (count == `LEN_LONG);
   assign frame_ok = frame_end && (short_len || long_len);
   assign take_bit = bit_valid && ctrl_enable && !long_len;
   assign next_count = count + 7'h01;
   // 16-bit lfsr for the all call dice
   assign next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};

   // short frames left-aligned, one position per field
   assign m = short_len ? {shreg[55:0], 56'h0} : shreg;
   // first field picks the layout
   assign f = m[111:107];
   assign elm_format = (f[4:3] == 2'b11);
   assign next_uf = elm_format ? `UF_ELM : f;

   // format groups
   assign is_surv = (f == `UF_SURV_ALT) || (f == `UF_SURV_ID);
   assign is_comm_a = (f == `UF_COMMA_ALT) || (f == `UF_COMMA_ID);

   // special surveillance fields, formats 0 and 16
   assign rl_field = m[103];
   assign aq_field = m[98];
   assign bds_field = m[97:90];
   assign mu_field = m[79:24];

   // surveillance and comm a fields
   assign pc_field = m[106:104];
   assign rr_field = m[103:99];
   assign di_field = m[98:96];
   assign sd_field = m[95:80];
   assign iis_field = m[95:92];
   assign ma_field = m[79:24];
   assign iis_present = (di_field == 3'h0) || (di_field == 3'h1) || (di_field == 3'h7);
   assign next_reply_source = rr_field[4] ? rr_field[3:0] : 4'h0;

   // all call fields
   assign pr_field = m[106:103];
   assign ii_field = m[102:99];

   // extended length fields
   assign rc_field = m[109:108];
   assign nc_field = m[107:104];
   assign mc_field = m[103:24];
   assign comm_d_field = (rc_field == 2'h3);

   // parity field ends every frame
   assign ap_field = short_len ? m[79:56] : m[23:0];

   // all call reply decision
   assign pr_no_reply = (pr_field[2:0] > 3'h4);
   assign pr_override = pr_field[3];
   always @* begin
      pr_mask = 4'h0;
      pr_reply = 1'b0;
      case (pr_field[2:0])
         3'h0: pr_mask = 4'h0;
         3'h1: pr_mask = 4'h1;
         3'h2: pr_mask = 4'h3;
         3'h3: pr_mask = 4'h7;
         3'h4: pr_mask = 4'hf;
         default: pr_mask = 4'h0;
      endcase
      if (!pr_no_reply)
         pr_reply = ((lfsr[3:0] & pr_mask) == 4'h0) && (pr_override || !lockout);
   end

   // designator kind
   always @* begin
      case (di_field)
         3'h0: next_sd_kind = 3'h1;
         3'h1: next_sd_kind = 3'h2;
         3'h2: next_sd_kind = 3'h3;
         3'h7: next_sd_kind = 3'h4;
         default: next_sd_kind = 3'h0;
      endcase
   end

   // close out, one-hot b, c, d
   always @* begin
      case (pc_field)
         3'h4: next_closeout = 3'b001;
         3'h5: next_closeout = 3'b010;
         3'h6: next_closeout = 3'b100;
         default: next_closeout = 3'b000;
      endcase
   end

   // bus handshake, write lands on the ack edge
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_done = wb_cyc_i & wb_stb_i & wb_ack_o;
   assign ctrl_write = bus_done && wb_we_i && (wb_adr_i[7:0] == `REG_CTRL) && wb_sel_i[0];
   assign lock_clear = ctrl_write && wb_dat_i[`CTRL_LOCK_CLR];
   // lockout command beats a clear in the same cycle
   assign lock_set = frame_ok && !elm_format && (is_surv || is_comm_a) &&
      (pc_field == 3'h1);
   assign status_word = {29'h0, lockout, count == 7'h00, ctrl_enable};

   // read data, unmapped offsets read zero
   always @* begin
      case (wb_adr_i[7:0])
         `REG_CTRL: next_rdata = ctrl;
         `REG_STATUS: next_rdata = status_word;
         `REG_FMT: next_rdata = frame_count;
         `REG_SURV: next_rdata = {uf, pc, rr, di, sd};
         `REG_MSG_LO: next_rdata = message[31:0];
         `REG_MSG_MID: next_rdata = message[63:32];
         `REG_MSG_HI: next_rdata = {16'h0, message[79:64]};
         `REG_ADDR: next_rdata = {8'h0, ap};
         default: next_rdata = 32'h0;
      endcase
   end

   // free-running dice
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lfsr <= 16'hace1;
      end else begin
         lfsr <= next_lfsr;
      end
   end

   // bit shifter, msb first, at most one long frame
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shreg <= 112'h0;
         count <= 7'h00;
      end else if (frame_end) begin
         shreg <= 112'h0;
         count <= 7'h00;
      end else if (take_bit) begin
         shreg <= {shreg[110:0], bit_in};
         count <= next_count;
      end
   end

   // register bus slave, one wait state
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= `CTRL_RESET_VAL;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i)
            wb_dat_o <= next_rdata;
         if (ctrl_write)
            ctrl[`CTRL_ENABLE] <= wb_dat_i[`CTRL_ENABLE];
      end
   end

   // frame decode and lockout state
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fields_valid <= 1'b0;
         uf <= 5'h00;
         aq_copy <= 1'b0;
         bds <= 8'h00;
         di <= 3'h0;
         ii <= 4'h0;
         iis <= 4'h0;
         sd <= 16'h0000;
         message <= 80'h0;
         msg_is_comm_a <= 1'b0;
         msg_is_air_air <= 1'b0;
         msg_is_elm <= 1'b0;
         nc <= 4'h0;
         rc <= 2'h0;
         comm_d_request <= 1'b0;
         pc <= 3'h0;
         lockout_cmd <= 1'b0;
         closeout <= 3'h0;
         pr <= 4'h0;
         rr <= 5'h00;
         long_reply <= 1'b0;
         reply_source <= 4'h0;
         reply_df16 <= 1'b0;
         reply_enable <= 1'b0;
         ap <= 24'h000000;
         sd_kind <= 3'h0;
         lockout <= 1'b0;
         frame_count <= 32'h0;
      end else begin
         // one-cycle pulses
         fields_valid <= 1'b0;
         lockout_cmd <= 1'b0;
         comm_d_request <= 1'b0;

         // clear first so a same-cycle lockout command wins
         if (lock_clear)
            lockout <= 1'b0;

         // everything below waits for a whole frame
         if (frame_ok) begin
            fields_valid <= 1'b1;
            frame_count <= frame_count + 32'h1;
            uf <= next_uf;
            ap <= ap_field;
            aq_copy <= aq_field;
            reply_df16 <= rl_field;
            bds <= bds_field;
            reply_enable <= 1'b1;
            msg_is_comm_a <= 1'b0;
            msg_is_air_air <= 1'b0;
            msg_is_elm <= 1'b0;
            if (elm_format) begin
               rc <= rc_field;
               nc <= nc_field;
               message <= mc_field;
               msg_is_elm <= 1'b1;
               comm_d_request <= comm_d_field;
            end else begin
               case (f)
                  `UF_ALL_CALL: begin
                     pr <= pr_field;
                     ii <= ii_field;
                     reply_enable <= pr_reply;
                  end
                  `UF_SURV_ALT, `UF_SURV_ID, `UF_COMMA_ALT, `UF_COMMA_ID: begin
                     pc <= pc_field;
                     rr <= rr_field;
                     di <= di_field;
                     sd <= sd_field;
                     sd_kind <= next_sd_kind;
                     long_reply <= rr_field[4];
                     reply_source <= next_reply_source;
                     closeout <= next_closeout;
                     if (iis_present)
                        iis <= iis_field;
                     if (lock_set) begin
                        lockout <= 1'b1;
                        lockout_cmd <= 1'b1;
                     end
                     if (is_comm_a) begin
                        message <= {24'h0, ma_field};
                        msg_is_comm_a <= 1'b1;
                     end
                  end
                  `UF_LONG_AIR: begin
                     message <= {24'h0, mu_field};
                     msg_is_air_air <= 1'b1;
                  end
                  default: begin
                     msg_is_comm_a <= 1'b0;
                  end
               endcase
            end
         end
      end
   end
endmodule // uplink_field_decoder
`default_nettype wire

// *** sim/uplink_decoder_props.sv ***
// assertions on the uplink field decoder ports
`default_nettype none
`include "uplink_decoder_regs.vh"
module uplink_decoder_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic frame_end,
   input wire logic fields_valid,
   input wire logic [4:0] uf,
   input wire logic [2:0] pc,
   input wire logic [3:0] pr,
   input wire logic [4:0] rr,
   input wire logic long_reply,
   input wire logic [3:0] reply_source,
   input wire logic reply_enable,
   input wire logic lockout_cmd,
   input wire logic lockout,
   input wire logic [1:0] rc,
   input wire logic comm_d_request
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire surv = fields_valid && (uf == `UF_SURV_ALT || uf == `UF_SURV_ID);
   wire call = fields_valid && uf == `UF_ALL_CALL;
   sequence s_lock_cmd;
      surv && pc == 3'h1 ##0 lockout_cmd;
   endsequence
   a_valid_cause: assert property (fields_valid |-> $past(frame_end))
      else $error("valid without frame end");
   a_valid_pulse: assert property (fields_valid |=> !fields_valid)
      else $error("valid longer than one cycle");
   a_fields_hold: assert property (!fields_valid |-> $stable(uf) && $stable(rr))
      else $error("fields moved without valid");
   a_long_rr: assert property (surv |-> long_reply == rr[4])
      else $error("reply length wrong");
   a_source_rr: assert property (surv && rr[4] |-> reply_source == rr[3:0])
      else $error("reply source wrong");
   a_lock_pulse: assert property (surv && pc == 3'h1 |-> lockout_cmd)
      else $error("no lockout command");
   a_lock_set: assert property (s_lock_cmd |=> lockout)
      else $error("lockout not entered");
   a_lock_quiet: assert property (call && lockout && !pr[3] |-> !reply_enable)
      else $error("all call answered in lockout");
   a_pr_refuse: assert property (call && pr[2:0] > 3'h4 |-> !reply_enable)
      else $error("reply on no-reply code");
   a_pr_sure: assert property (call && pr[2:0] == 3'h0 && (pr[3] || !lockout) |-> reply_enable)
      else $error("certain reply missing");
   a_comm_d: assert property (comm_d_request |-> fields_valid && rc == 2'h3)
      else $error("comm d request without final segment");
endmodule // uplink_decoder_props
bind uplink_field_decoder uplink_decoder_props i_props (.clk, .rstn, .frame_end, .fields_valid,
   .uf, .pc, .pr, .rr, .long_reply, .reply_source, .reply_enable, .lockout_cmd, .lockout, .rc,
   .comm_d_request);
`default_nettype wire

// *** sim/ground_interrogator.sv ***
// interrogator model driving the demodulated bit stream
`default_nettype none
module ground_interrogator (
   input wire logic clk,
   output logic bit_in,
   output logic bit_valid,
   output logic frame_end
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      bit_in = 1'b0;
      bit_valid = 1'b0;
      frame_end = 1'b0;
   end
   // msb first, parity field last, gap idle cycles per bit
   task automatic send(input logic [111:0] f, input int n, input int gap);
      for (int k = n - 1; k >= 0; k--) begin
         @(posedge clk);
         bit_in <= f[k];
         bit_valid <= 1'b1;
         repeat (gap) begin
            @(posedge clk);
            bit_valid <= 1'b0;
            bit_in <= ~f[k];
         end
      end
      @(posedge clk);
      bit_valid <= 1'b0;
      bit_in <= ~f[0];
      frame_end <= 1'b1;
      @(posedge clk);
      frame_end <= 1'b0;
   endtask
endmodule // ground_interrogator
`default_nettype wire

// *** sim/uplink_field_decoder_tb.sv ***
// self-checking bench for the uplink field decoder
`default_nettype none
`include "uplink_decoder_regs.vh"
module uplink_field_decoder_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rstn = 1'b0, wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, q;
   logic [3:0] wb_sel_i = 4'hf;
   wire logic bit_in, bit_valid, frame_end, wb_ack_o, fields_valid, aq_copy, msg_is_comm_a;
   wire logic msg_is_elm, comm_d_request, lockout_cmd, long_reply, reply_df16, reply_enable;
   wire logic lockout, msg_is_air_air;
   wire logic [31:0] wb_dat_o;
   wire logic [4:0] uf, rr;
   wire logic [7:0] bds;
   wire logic [2:0] di, pc, closeout, sd_kind;
   wire logic [3:0] ii, iis, nc, pr, reply_source;
   wire logic [15:0] sd;
   wire logic [79:0] message;
   wire logic [1:0] rc;
   wire logic [23:0] ap;
   int n_errors = 0, checked = 0;
   // frame, long reply, sd kind
   logic [59:0] rows [4] = '{
      {5'h04, 3'h0, 5'h10, 3'h0, 16'h1234, 24'habcdef, 1'b1, 3'h1},
      {5'h05, 3'h4, 5'h0f, 3'h1, 16'h5a5a, 24'h123456, 1'b0, 3'h2},
      {5'h04, 3'h5, 5'h13, 3'h2, 16'hc3c3, 24'h00ff00, 1'b1, 3'h3},
      {5'h05, 3'h6, 5'h1f, 3'h7, 16'hffff, 24'hfedcba, 1'b1, 3'h4}};
   uplink_field_decoder i_uplink_field_decoder (.*);
   ground_interrogator i_ground_interrogator (.clk, .bit_in, .bit_valid, .frame_end);
   always #12.5 clk = ~clk;
   task print_verdict;
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task chk(input logic [79:0] got, input logic [79:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task frame(input logic [111:0] f, input int n, input int gap);
      int i;
      i_ground_interrogator.send(f, n, gap);
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (fields_valid !== 1'b1 && i < 9);
      if (fields_valid !== 1'b1) begin
         n_errors++;
         print_verdict();
      end
   endtask
   task allcall(input logic [3:0] p, input logic e);
      frame({56'h0, `UF_ALL_CALL, p, 4'h9, 19'h7ffff, 24'h13579b}, 56, 0);
      chk(ii, 4'h9);
      chk(reply_enable, e);
   endtask
   task wb(input logic we, input logic [31:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      if (wb_ack_o !== 1'b1) begin
         n_errors++;
         print_verdict();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         frame({56'h0, rows[i][59:4]}, 56, i % 2);
         chk(uf, rows[i][59:55]);
         chk(pc, rows[i][54:52]);
         chk(rr, rows[i][51:47]);
         chk(di, rows[i][46:44]);
         chk(sd, rows[i][43:28]);
         chk(ap, rows[i][27:4]);
         chk(long_reply, rows[i][3]);
         chk(sd_kind, rows[i][2:0]);
         $display("row %0d done", i);
      end
      chk(iis, 4'hf);
      chk(closeout, 3'b100);
      allcall(4'h0, 1'b1);
      frame({56'h0, 5'h04, 3'h1, 5'h00, 3'h0, 16'h0, 24'h0}, 56, 0);
      chk(lockout_cmd, 1'b1);
      @(negedge clk);
      chk(lockout, 1'b1);
      allcall(4'h0, 1'b0);
      allcall(4'h8, 1'b1);
      allcall(4'h5, 1'b0);
      allcall(4'hd, 1'b0);
      $display("all call done");
      frame({56'h0, 5'h00, 3'h0, 1'b1, 4'h0, 1'b1, 8'ha5, 10'h0, 24'h0}, 56, 0);
      chk(reply_df16, 1'b1);
      chk(aq_copy, 1'b1);
      chk(bds, 8'ha5);
      frame({5'h14, 3'h0, 5'h00, 3'h0, 16'h0, 56'h11223344556677, 24'h0}, 112, 1);
      chk(message, {24'h0, 56'h11223344556677});
      chk(msg_is_comm_a, 1'b1);
      frame({5'h10, 27'h0, 56'h77665544332211, 24'h0}, 112, 0);
      chk(message, {24'h0, 56'h77665544332211});
      chk(msg_is_comm_a, 1'b0);
      chk(msg_is_air_air, 1'b1);
      frame({2'b11, 2'h3, 4'h5, 80'h0123456789abcdef0123, 24'h0}, 112, 0);
      chk(uf, `UF_ELM);
      chk(rc, 2'h3);
      chk(nc, 4'h5);
      chk(message, 80'h0123456789abcdef0123);
      chk(comm_d_request, 1'b1);
      $display("long frames done");
      wb(1'b1, `REG_CTRL, 32'h3);
      wb(1'b0, `REG_STATUS, 32'h0);
      chk(q[2], 1'b0);
      wb(1'b0, 32'h40, 32'h0);
      chk(q, 32'h0);
      $display("register test done");
      @(posedge clk);
      rstn <= 1'b0;
      @(negedge clk);
      chk(uf, 5'h0);
      @(posedge clk);
      rstn <= 1'b1;
      wb(1'b0, `REG_CTRL, 32'h0);
      chk(q, `CTRL_RESET_VAL);
      $display("reset test done");
      print_verdict();
   end
endmodule // uplink_field_decoder_tb
`default_nettype wire
